// ===== hw/flp_cfg.svh
/*
 * Numbers of the FIFO level and power register group.
 * Assumes a 200 MHz clock and byte addresses on an 8-bit address bus.
 */
`ifndef FLP_CFG_SVH
`define FLP_CFG_SVH

// ------------
// register offsets
// ------------
`define FLP_ADDR_W         8
`define FLP_OFF_BYTE_TEST  8'h64
`define FLP_OFF_RX_LEVEL   8'h7C
`define FLP_OFF_TX_LEVEL   8'h80
`define FLP_OFF_POWER_CTRL 8'h84

// ------------
// field positions and reset values
// ------------
`define FLP_STAT_MSB       23
`define FLP_STAT_LSB       16
`define FLP_DATA_MSB       15
`define FLP_PS_MSB         13
`define FLP_PS_LSB         12
`define FLP_PHY_SELF_TIMED_RESET_BIT    10
`define FLP_WAKE_FRAME_EVENT_ENABLE_BIT     9
`define FLP_ENERGY_DETECT_EVENT_ENABLE_BIT      8
`define FLP_BUF_KIND_BIT   6
`define FLP_PULSE_BIT      3
`define FLP_POL_BIT        2
`define FLP_OUT_EN_BIT     1
`define FLP_READY_BIT      0
`define FLP_STAT_RESET     8'h00
`define FLP_RX_DATA_RESET  16'h0000
`define FLP_TX_FREE_RESET  16'h1200
`define FLP_DWORD_BYTES    16'h0004
`define FLP_BYTE_TEST_VAL  32'hA5C3_0F96

// ------------
// timing
// ------------
`define FLP_CLK_MHZ        200
`define FLP_PHY_SELF_TIMED_RESET_US     100
`define FLP_PHY_SELF_TIMED_RESET_CYC    (`FLP_PHY_SELF_TIMED_RESET_US * `FLP_CLK_MHZ)
`define FLP_PULSE_MS       50
`define FLP_PULSE_CYC      (`FLP_PULSE_MS * 1000 * `FLP_CLK_MHZ)
`define FLP_READY_CYC      16

`endif

// ===== hw/flp_pkg.sv
/*
 * Types of the register group; the power state type is shared by both ends, the host sequencer states are the host's own.
 * Assumes flp_cfg.svh supplies the numbers.
 */
package flp_pkg;
   // power state encoding, natural order gives 00b..11b
   typedef enum logic [1:0] {
      PS_NORMAL,
      PS_WAKE_FRAME,
      PS_ENERGY_DETECT,
      PS_RESERVED
   } flp_power_state_t;

   // host sequencer states
   typedef enum logic [2:0] {
      HS_IDLE,
      HS_PRE_READ,
      HS_PRE_WAIT,
      HS_ISSUE,
      HS_WAIT,
      HS_DONE
   } flp_host_state_t;
endpackage

// ===== hw/flp_if.sv
/*
 * Register bus between the host end and the device end.
 * Assumes one clock; read data stand in the cycle after the read strobe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flp_cfg.svh"

interface flp_if (
   input wire logic clk,
   input wire logic reset_n
);
   logic [`FLP_ADDR_W-1:0] addr;
   logic [31:0]            wdata;
   logic                   wr;
   logic                   rd;
   logic                   txPush;
   logic [31:0]            rdata;

   modport dev (
      input  clk, reset_n, addr, wdata, wr, rd, txPush,
      output rdata
   );
   modport host (
      input  clk, reset_n, rdata,
      output addr, wdata, wr, rd, txPush
   );
endinterface
`default_nettype wire

// ===== hw/flp_host.sv
/*
 * Host end: single commands to bus cycles, keeping the host's duties, except that pushes around a tx level read are not deducted from its credit.
 * Assumes the device end of flp_if on the far side of the bus.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flp_cfg.svh"

module flp_host (
   flp_if.host                    bus,
   input  wire logic              cmdValid,
   input  wire logic              cmdWrite,
   input  wire logic [`FLP_ADDR_W-1:0] cmdAddr,
   input  wire logic [31:0]       cmdData,
   input  wire logic              txDataReq,
   output logic                   cmdBusy,
   output logic                   cmdDone,
   output logic                   cmdRefused,
   output logic [31:0]            cmdReadData,
   output logic                   txDataRefused
);
   typedef struct packed {
      flp_pkg::flp_host_state_t st;
      logic                   needRead;
      logic                   write;
      logic [`FLP_ADDR_W-1:0] addr;
      logic [31:0]            data;
      logic [15:0]            txCredit;
      logic                   busWr;
      logic                   busRd;
      logic                   busPush;
      logic                   done;
      logic                   refused;
      logic                   txRef;
      logic [31:0]            rdData;
   } flp_host_s_t;

   flp_host_s_t s_reg;
   flp_host_s_t s_next;

   // ------------
   // sequencer
   // ------------
   always_comb begin
      s_next         = s_reg;
      s_next.busWr   = 1'b0;
      s_next.busRd   = 1'b0;
      s_next.busPush = 1'b0;
      s_next.done    = 1'b0;
      s_next.refused = 1'b0;
      s_next.txRef   = 1'b0;
      // a data push only spends credit learnt from the tx level read
      if (txDataReq) begin
         if (s_reg.txCredit >= `FLP_DWORD_BYTES) begin
            s_next.busPush  = 1'b1;
            s_next.txCredit = s_reg.txCredit - `FLP_DWORD_BYTES;
         end else begin
            s_next.txRef = 1'b1;
         end
      end
      case (s_reg.st)
         flp_pkg::HS_IDLE: begin
            if (cmdValid) begin
               s_next.write = cmdWrite;
               s_next.addr  = cmdAddr;
               s_next.data  = cmdData;
               if (cmdWrite && cmdAddr == `FLP_OFF_POWER_CTRL &&
                   cmdData[`FLP_PS_MSB:`FLP_PS_LSB] == 2'(flp_pkg::PS_RESERVED)) begin
                  s_next.refused = 1'b1; // reserved power state
                  s_next.done    = 1'b1;
               end else if (cmdWrite && cmdAddr != `FLP_OFF_BYTE_TEST) begin
                  s_next.st = flp_pkg::HS_PRE_READ; // check ready first
               end else begin
                  s_next.st = flp_pkg::HS_ISSUE;
               end
            end
         end
         flp_pkg::HS_PRE_READ: begin
            // strobe for one cycle; the data stand in the cycle after it
            s_next.busRd = !s_reg.busRd;
            if (s_reg.busRd) begin
               s_next.st = flp_pkg::HS_PRE_WAIT;
            end
         end
         flp_pkg::HS_PRE_WAIT: begin
            s_next.st       = flp_pkg::HS_DONE;
            s_next.needRead = 1'b0; // the check read also counts
            if (bus.rdata[`FLP_READY_BIT]) begin
               s_next.st = flp_pkg::HS_ISSUE; // ready seen
            end else begin
               s_next.refused = 1'b1;
               s_next.done    = 1'b1;
            end
         end
         flp_pkg::HS_ISSUE: begin
            if (s_reg.write && s_reg.needRead) begin
               s_next.st = flp_pkg::HS_PRE_READ; // read before any write
            end else begin
               s_next.busWr = s_reg.write;
               s_next.busRd = !s_reg.write;
               s_next.st    = s_reg.write ? flp_pkg::HS_DONE : flp_pkg::HS_WAIT;
               if (s_reg.write) begin
                  s_next.done = 1'b1;
                  // a wake write starts a new read-first period
                  if (s_reg.addr == `FLP_OFF_BYTE_TEST) begin
                     s_next.needRead = 1'b1;
                  end
               end
            end
         end
         flp_pkg::HS_WAIT: begin
            // the strobe cycle passes first; data are taken where they stand
            if (!s_reg.busRd) begin
               s_next.rdData   = bus.rdata;
               s_next.needRead = 1'b0;
               s_next.done     = 1'b1;
               s_next.st       = flp_pkg::HS_DONE;
               if (s_reg.addr == `FLP_OFF_TX_LEVEL) begin
                  s_next.txCredit = bus.rdata[`FLP_DATA_MSB:0]; // refresh credit
               end
            end
         end
         default: begin
            s_next.st = flp_pkg::HS_IDLE;
         end
      endcase
   end

   // state register; a read is owed after reset
   always_ff @(posedge bus.clk) begin
      if (!bus.reset_n) begin
         s_reg          <= '0;
         s_reg.st       <= flp_pkg::HS_IDLE;
         s_reg.needRead <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign bus.addr      = s_reg.addr;
   assign bus.wdata     = s_reg.data;
   assign bus.wr        = s_reg.busWr;
   assign bus.rd        = s_reg.busRd;
   assign bus.txPush    = s_reg.busPush;
   assign cmdBusy       = (s_reg.st != flp_pkg::HS_IDLE);
   assign cmdDone       = s_reg.done;
   assign cmdRefused    = s_reg.refused;
   assign cmdReadData   = s_reg.rdData;
   assign txDataRefused = s_reg.txRef;
endmodule
`default_nettype wire

// ===== hw/flp_device.sv
/*
 * Device end: FIFO level and power registers.
 * Assumes one-cycle datapath event pulses and the host end on flp_if.
 */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "flp_cfg.svh"

// Summary of operation
// - rx status used dwords in bits 23-16
// - rx data used bytes in bits 15-0
// - frame length adds, rounded up to dword
// - tx status used dwords in bits 23-16
// - tx data free bytes, reset 1200h
// - host never overfills tx data space; pushes around a tx level read are not deducted from the host credit
// - power control readable in low power
// - writes ignored until first read
// - power state field selects operating mode
// - host never programs reserved state 11b
// - byte test write wakes device
// - host writes nothing else while not ready
// - phy reset self-timed 100us, self-clearing
// - phy reset writes ignored while set
// - wake frame event drives output, interrupt
// - energy event drives output, interrupt
// - buffer kind: open-drain low or push-pull
// - output enable gates pin, not interrupt
// - pulse mode 50ms, else continuous level
// - ready flag set once stable
module flp_device #(
   parameter int unsigned PHY_SELF_TIMED_RESET_CYC = `FLP_PHY_SELF_TIMED_RESET_CYC,
   parameter int unsigned PULSE_CYC   = `FLP_PULSE_CYC,
   parameter int unsigned READY_CYC   = `FLP_READY_CYC
) (
   flp_if.dev                 bus,
   input  wire logic          rxStatusPush,
   input  wire logic          rxStatusPop,
   input  wire logic          rxFrameDone,
   input  wire logic [15:0]   rxFrameLen,
   input  wire logic          rxDataPopDword,
   input  wire logic          txStatusPush,
   input  wire logic          txStatusPop,
   input  wire logic          txDataDrainDword,
   input  wire logic          wakeFrameEvent,
   input  wire logic          energyDetectEvent,
   output logic [1:0]         powerState,
   output logic               deviceReady,
   output logic               phyReset,
   output logic               wakeInterrupt,
   output logic               wakeOutputO,
   output logic               wakeOutputOe
);
   typedef struct packed {
      logic [7:0]  rxStatUsed;
      logic [15:0] rxDataUsed;
      logic [7:0]  txStatUsed;
      logic [15:0] txFree;
      logic [1:0]  pmMode;
      logic        phyRst;
      logic        wolEn;
      logic        edEn;
      logic        bufKind;
      logic        pulseMode;
      logic        polarity;
      logic        outEn;
      logic        ready;
      logic        readSeen;
      logic [31:0] readyCnt;
      logic [31:0] phyCnt;
      logic [31:0] pulseCnt;
      logic        wakeActive;
      logic        pinO;
      logic        pinOe;
      logic [31:0] rdData;
   } flp_dev_s_t;

   flp_dev_s_t s_reg;
   flp_dev_s_t s_next;

   // ------------
   // helpers
   // ------------
   // round a byte count up to a whole dword
   function automatic logic [15:0] round_dword(input logic [15:0] len);
      round_dword = (len + 16'h0003) & 16'hFFFC;
   endfunction

   // counter step for a push and a pop in the same cycle
   function automatic logic [7:0] step8(input logic [7:0] v,
                                         input logic up,
                                         input logic dn);
      step8 = v + {7'h00, up} - {7'h00, dn};
   endfunction

   // read mux; unmapped and reserved bits read as zero
   function automatic logic [31:0] reg_read(input flp_dev_s_t s,
                                            input logic [`FLP_ADDR_W-1:0] a);
      reg_read = 32'h0000_0000;
      if (a == `FLP_OFF_RX_LEVEL) begin
         reg_read[`FLP_STAT_MSB:`FLP_STAT_LSB] = s.rxStatUsed;
         reg_read[`FLP_DATA_MSB:0]             = s.rxDataUsed;
      end else if (a == `FLP_OFF_TX_LEVEL) begin
         reg_read[`FLP_STAT_MSB:`FLP_STAT_LSB] = s.txStatUsed;
         reg_read[`FLP_DATA_MSB:0]             = s.txFree;
      end else if (a == `FLP_OFF_POWER_CTRL) begin
         // no power gating on this path, readable in every state
         reg_read[`FLP_PS_MSB:`FLP_PS_LSB] = s.pmMode;
         reg_read[`FLP_PHY_SELF_TIMED_RESET_BIT]        = s.phyRst;
         reg_read[`FLP_WAKE_FRAME_EVENT_ENABLE_BIT]         = s.wolEn;
         reg_read[`FLP_ENERGY_DETECT_EVENT_ENABLE_BIT]          = s.edEn;
         reg_read[`FLP_BUF_KIND_BIT]       = s.bufKind;
         reg_read[`FLP_PULSE_BIT]          = s.pulseMode;
         reg_read[`FLP_POL_BIT]            = s.polarity;
         reg_read[`FLP_OUT_EN_BIT]         = s.outEn;
         reg_read[`FLP_READY_BIT]          = s.ready;
      end else if (a == `FLP_OFF_BYTE_TEST) begin
         reg_read = `FLP_BYTE_TEST_VAL;
      end
   endfunction

   // ------------
   // next state
   // ------------
   logic lowPower;
   logic wakeWrite;
   logic wrOk;
   logic evt;
   logic asserted;

   always_comb begin
      s_next    = s_reg;
      lowPower  = (s_reg.pmMode != 2'(flp_pkg::PS_NORMAL));
      // byte test write wakes even before the first read
      wakeWrite = bus.wr && lowPower && bus.addr == `FLP_OFF_BYTE_TEST;
      wrOk      = bus.wr && s_reg.readSeen;

      // fifo levels track datapath events
      s_next.rxStatUsed = step8(s_reg.rxStatUsed, rxStatusPush, rxStatusPop);
      s_next.txStatUsed = step8(s_reg.txStatUsed, txStatusPush, txStatusPop);
      s_next.rxDataUsed = s_reg.rxDataUsed
                        + (rxFrameDone ? round_dword(rxFrameLen) : 16'h0000)
                        - (rxDataPopDword ? `FLP_DWORD_BYTES : 16'h0000);
      // free space relies on the host not overfilling it
      s_next.txFree = s_reg.txFree
                    - (bus.txPush ? `FLP_DWORD_BYTES : 16'h0000)
                    + (txDataDrainDword ? `FLP_DWORD_BYTES : 16'h0000);

      // any read arms writes
      if (bus.rd) begin
         s_next.readSeen = 1'b1;
      end
      s_next.rdData = bus.rd ? reg_read(s_reg, bus.addr) : 32'h0000_0000;

      // ready counter; ready only in normal state once the count expires
      if (s_reg.readyCnt != 32'h0) begin
         s_next.readyCnt = s_reg.readyCnt - 32'h1;
      end
      s_next.ready = !lowPower && s_reg.readyCnt == 32'h0;

      // self-timed phy reset
      if (s_reg.phyRst) begin
         if (s_reg.phyCnt <= 32'h1) begin
            s_next.phyRst = 1'b0; // self clear after the hold
            s_next.phyCnt = 32'h0;
         end else begin
            s_next.phyCnt = s_reg.phyCnt - 32'h1;
         end
      end

      if (wakeWrite) begin
         // back to normal; a fresh read and settle period follow
         s_next.pmMode   = 2'(flp_pkg::PS_NORMAL);
         s_next.readSeen = 1'b0;
         s_next.ready    = 1'b0;
         s_next.readyCnt = READY_CYC;
      end else if (wrOk && bus.addr == `FLP_OFF_POWER_CTRL) begin
         s_next.pmMode    = bus.wdata[`FLP_PS_MSB:`FLP_PS_LSB];
         s_next.wolEn     = bus.wdata[`FLP_WAKE_FRAME_EVENT_ENABLE_BIT];
         s_next.edEn      = bus.wdata[`FLP_ENERGY_DETECT_EVENT_ENABLE_BIT];
         s_next.bufKind   = bus.wdata[`FLP_BUF_KIND_BIT];
         s_next.pulseMode = bus.wdata[`FLP_PULSE_BIT];
         s_next.polarity  = bus.wdata[`FLP_POL_BIT];
         s_next.outEn     = bus.wdata[`FLP_OUT_EN_BIT];
         // a low power entry drops ready at once
         if (bus.wdata[`FLP_PS_MSB:`FLP_PS_LSB] != 2'(flp_pkg::PS_NORMAL)) begin
            s_next.ready = 1'b0;
         end
         // writes while set are ignored
         if (!s_reg.phyRst && bus.wdata[`FLP_PHY_SELF_TIMED_RESET_BIT]) begin
            s_next.phyRst = 1'b1;
            s_next.phyCnt = PHY_SELF_TIMED_RESET_CYC; // hold for the full minimum
         end
      end

      // wake events; the new enables gate them, so clearing the enables wins over a set
      evt = (wakeFrameEvent && s_next.wolEn) ||
            (energyDetectEvent && s_next.edEn);
      if (!s_next.wolEn && !s_next.edEn) begin
         s_next.wakeActive = 1'b0;
      end
      if (evt) begin
         s_next.wakeActive = 1'b1;
      end
      if (evt && s_next.pulseMode) begin
         s_next.pulseCnt = PULSE_CYC; // one pulse per event
      end else if (s_reg.pulseCnt != 32'h0) begin
         s_next.pulseCnt = s_reg.pulseCnt - 32'h1;
      end
      if (!s_next.wakeActive) begin
         s_next.pulseCnt = 32'h0;
      end

      // pulse or continuous level
      asserted = s_next.pulseMode ? (s_next.pulseCnt != 32'h0) : s_next.wakeActive;
      if (!s_next.outEn) begin
         s_next.pinO  = 1'b0;  // pin released while disabled
         s_next.pinOe = 1'b0;
      end else if (!s_next.bufKind) begin
         s_next.pinO  = 1'b0;  // open drain, active low, polarity ignored
         s_next.pinOe = asserted;
      end else begin
         s_next.pinO  = s_next.polarity ? asserted : !asserted; // push-pull
         s_next.pinOe = 1'b1;
      end
   end

   // ------------
   // state register
   // ------------
   always_ff @(posedge bus.clk) begin
      if (!bus.reset_n) begin
         s_reg            <= '0;
         s_reg.rxStatUsed <= `FLP_STAT_RESET;
         s_reg.rxDataUsed <= `FLP_RX_DATA_RESET;
         s_reg.txStatUsed <= `FLP_STAT_RESET;
         s_reg.txFree     <= `FLP_TX_FREE_RESET;
         s_reg.readyCnt   <= READY_CYC;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs straight from the state register
   assign bus.rdata     = s_reg.rdData;
   assign powerState    = s_reg.pmMode;
   assign deviceReady   = s_reg.ready;
   assign phyReset      = s_reg.phyRst;
   assign wakeInterrupt = s_reg.wakeActive; // not gated by output enable
   assign wakeOutputO   = s_reg.pinO;
   assign wakeOutputOe  = s_reg.pinOe;
endmodule
`default_nettype wire

// ===== test/flp_bus_properties.sv
/*
 * Bus checker on flp_if.
 * Assumes one clock, synchronous active-low reset, and the host end as bus master.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flp_cfg.svh"

module flp_bus_properties (
   input wire logic                   clk,
   input wire logic                   reset_n,
   input wire logic [`FLP_ADDR_W-1:0] addr,
   input wire logic [31:0]            wdata,
   input wire logic                   wr,
   input wire logic                   rd,
   input wire logic                   txPush,
   input wire logic [31:0]            rdata
);
   logic                   rdPrev;
   logic [`FLP_ADDR_W-1:0] addrPrev;
   logic                   seenRead;
   logic                   readyKept;
   logic [15:0]            credit;
   logic                   readyNow;
   logic [15:0]            creditNow;

   // read data count in the cycle they stand
   assign readyNow  = (rdPrev && addrPrev == `FLP_OFF_POWER_CTRL) ? rdata[0] : readyKept;
   assign creditNow = (rdPrev && addrPrev == `FLP_OFF_TX_LEVEL) ? rdata[15:0] : credit;

   // host knowledge; a write makes the host look again
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdPrev    <= 1'b0;
         addrPrev  <= '0;
         seenRead  <= 1'b0;
         readyKept <= 1'b0;
         credit    <= 16'h0000;
      end else begin
         rdPrev    <= rd;
         addrPrev  <= addr;
         seenRead  <= wr ? 1'b0 : (seenRead | rd);
         readyKept <= wr ? 1'b0 : readyNow;
         credit    <= creditNow - (txPush ? 16'h0004 : 16'h0000);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_read(a);
      rd && addr == a;
   endsequence

   // ------------
   // properties
   // ------------
   a_strobe_exclusive: assert property (!(wr && rd))
      else $error("read and write strobes together");
   a_rx_reserved_zero: assert property (s_read(`FLP_OFF_RX_LEVEL) |=> rdata[31:24] == 8'h00)
      else $error("rx level top byte not zero");
   a_tx_reserved_zero: assert property (s_read(`FLP_OFF_TX_LEVEL) |=> rdata[31:24] == 8'h00)
      else $error("tx level top byte not zero");
   a_tx_free_bound: assert property (s_read(`FLP_OFF_TX_LEVEL) |=> rdata[15:0] <= 16'h1200)
      else $error("tx free above capacity");
   a_pwr_reserved_zero: assert property (s_read(`FLP_OFF_POWER_CTRL) |=>
      (rdata[31:14] == 18'h0 && !rdata[11] && !rdata[7]))
      else $error("power control reserved bits set");
   a_unmapped_zero: assert property (rd && addr != `FLP_OFF_POWER_CTRL
      && addr != `FLP_OFF_TX_LEVEL && addr != `FLP_OFF_RX_LEVEL
      && addr != `FLP_OFF_BYTE_TEST |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   a_state_legal: assert property (wr && addr == `FLP_OFF_POWER_CTRL |-> wdata[13:12] != 2'h3)
      else $error("reserved power state written");
   a_read_first: assert property (wr && addr != `FLP_OFF_BYTE_TEST |-> seenRead)
      else $error("write without a read before it");
   a_ready_first: assert property (wr && addr != `FLP_OFF_BYTE_TEST |-> readyNow)
      else $error("write while device not ready");
   a_tx_credit_kept: assert property (txPush |-> creditNow >= 16'h0004)
      else $error("tx push beyond free space");
endmodule
`default_nettype wire

// ===== test/fifo_level_and_power_regs_tb_top.sv
/*
 * Testbench: both ends joined by flp_if, driven by host commands.
 * Assumes a pull-up on the wake pin and shortened phy reset and pulse counts.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flp_cfg.svh"

module fifo_level_and_power_regs_tb_top;
   logic clk, reset_n, cmdValid, cmdWrite, txDataReq, cmdBusy, cmdDone, cmdRefused;
   logic txDataRefused, rxStatusPush, rxStatusPop, rxFrameDone, rxDataPopDword;
   logic txStatusPush, txStatusPop, txDataDrainDword, wakeFrameEvent, energyDetectEvent;
   logic deviceReady, phyReset, wakeInterrupt, wakeOutputO, wakeOutputOe, refd;
   logic [7:0]  cmdAddr;
   logic [31:0] cmdData, cmdReadData, rdv;
   logic [15:0] rxFrameLen;
   logic [1:0]  powerState;
   int          miscompares = 0;
   int          totalChecks = 0;
   int          phyHigh = 0;
   wire         wakeWire = wakeOutputOe ? wakeOutputO : 1'b1; // pull-up when released

   flp_if u_flp_if (.clk(clk), .reset_n(reset_n));
   flp_host u_flp_host (.bus(u_flp_if), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
      .cmdAddr(cmdAddr), .cmdData(cmdData), .txDataReq(txDataReq), .cmdBusy(cmdBusy),
      .cmdDone(cmdDone), .cmdRefused(cmdRefused), .cmdReadData(cmdReadData),
      .txDataRefused(txDataRefused));
   flp_device #(.PHY_SELF_TIMED_RESET_CYC(50), .PULSE_CYC(100), .READY_CYC(16)) u_flp_device (
      .bus(u_flp_if), .rxStatusPush(rxStatusPush), .rxStatusPop(rxStatusPop),
      .rxFrameDone(rxFrameDone), .rxFrameLen(rxFrameLen), .rxDataPopDword(rxDataPopDword),
      .txStatusPush(txStatusPush), .txStatusPop(txStatusPop),
      .txDataDrainDword(txDataDrainDword), .wakeFrameEvent(wakeFrameEvent),
      .energyDetectEvent(energyDetectEvent), .powerState(powerState),
      .deviceReady(deviceReady), .phyReset(phyReset), .wakeInterrupt(wakeInterrupt),
      .wakeOutputO(wakeOutputO), .wakeOutputOe(wakeOutputOe));
   flp_bus_properties u_flp_bus_properties (.clk(clk), .reset_n(reset_n),
      .addr(u_flp_if.addr), .wdata(u_flp_if.wdata), .wr(u_flp_if.wr), .rd(u_flp_if.rd),
      .txPush(u_flp_if.txPush), .rdata(u_flp_if.rdata));

   // ------------
   // helpers
   // ------------
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      totalChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %b exp %b", $time, got, exp);
      end
   endtask
   // one host command, bounded so a hang shows
   task cmd(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cmdValid <= 1'b1;
      cmdWrite <= w;
      cmdAddr  <= a;
      cmdData  <= d;
      @(posedge clk);
      cmdValid <= 1'b0;
      n = 0;
      while (cmdDone !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      rdv  = cmdReadData;
      refd = cmdRefused;
      @(posedge clk);
      while (cmdBusy !== 1'b0 && n < 60) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) begin
         miscompares++;
         $display("BAD %0t command hung", $time);
      end
   endtask
   task wait_ready(output int n);
      n = 0;
      while (deviceReady !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
   endtask

   // ------------
   // scenarios
   // ------------
   task t_reset();
      int n;
      wait_ready(n);
      chk_bit(n >= 16 && n <= 19, 1'b1);
      cmd(0, `FLP_OFF_RX_LEVEL, 0);
      chk_word(rdv, 32'h0000_0000);
      cmd(0, `FLP_OFF_TX_LEVEL, 0);
      chk_word(rdv, 32'h0000_1200);
      cmd(0, `FLP_OFF_POWER_CTRL, 0);
      chk_word(rdv, 32'h0000_0001);
      $display("reset done");
   endtask
   // lengths 5 and 8 both add 8 bytes
   task t_levels();
      @(posedge clk);
      {rxStatusPush, rxFrameDone, txStatusPush, rxFrameLen} <= {3'h7, 16'h0005};
      @(posedge clk);
      rxFrameLen <= 16'h0008;
      @(posedge clk);
      {rxStatusPush, rxFrameDone, rxDataPopDword} <= 3'h1;
      @(posedge clk);
      {rxDataPopDword, txStatusPush, txStatusPop, txDataDrainDword} <= 4'h3;
      @(posedge clk);
      {txStatusPop, txDataDrainDword} <= 2'h0;
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         txDataReq <= 1'b1;
         @(posedge clk);
         txDataReq <= 1'b0;
         @(posedge clk);
      end
      cmd(0, `FLP_OFF_RX_LEVEL, 0);
      chk_word(rdv, 32'h0002_000C);
      cmd(0, `FLP_OFF_TX_LEVEL, 0);
      chk_word(rdv, 32'h0002_11FC);
      $display("levels done");
   endtask
   task t_wake_pin();
      cmd(1, `FLP_OFF_POWER_CTRL, 32'hFFFF_CBCF);
      cmd(0, `FLP_OFF_POWER_CTRL, 0);
      chk_word(rdv, 32'h0000_034F);
      @(posedge clk) wakeFrameEvent <= 1'b1;
      @(posedge clk) wakeFrameEvent <= 1'b0;
      @(posedge clk);
      chk_bit(wakeInterrupt, 1'b1);
      repeat (97) @(posedge clk);
      chk_bit(wakeWire, 1'b1);
      repeat (5) @(posedge clk);
      chk_bit(wakeWire, 1'b0);
      cmd(1, `FLP_OFF_POWER_CTRL, 0);
      chk_bit(wakeInterrupt | wakeOutputOe, 1'b0);
      cmd(1, `FLP_OFF_POWER_CTRL, 32'h0000_0102);
      @(posedge clk) energyDetectEvent <= 1'b1;
      @(posedge clk) energyDetectEvent <= 1'b0;
      repeat (150) @(posedge clk);
      chk_bit(wakeWire, 1'b0);
      cmd(1, `FLP_OFF_POWER_CTRL, 32'h0000_0100);
      chk_bit(wakeWire, 1'b1);
      chk_bit(wakeInterrupt, 1'b1);
      cmd(1, `FLP_OFF_POWER_CTRL, 0);
      $display("wake done");
   endtask
   // counts held cycles of the phy reset
   always @(posedge clk) if (phyReset === 1'b1) phyHigh <= phyHigh + 1;
   task t_phy_reset();
      int n;
      cmd(1, `FLP_OFF_POWER_CTRL, 32'h0000_0400);
      chk_bit(phyReset, 1'b1);
      cmd(1, `FLP_OFF_POWER_CTRL, 0);
      cmd(0, `FLP_OFF_POWER_CTRL, 0);
      chk_word(rdv, 32'h0000_0401);
      n = 0;
      while (phyReset === 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk_bit(phyHigh >= 50 && phyHigh <= 51, 1'b1);
      cmd(0, `FLP_OFF_POWER_CTRL, 0);
      chk_word(rdv, 32'h0000_0001);
      $display("phy done");
   endtask
   task t_power_state();
      int n;
      for (int s = 1; s < 3; s++) begin
         cmd(1, `FLP_OFF_POWER_CTRL, 32'(s) << 12);
         cmd(0, `FLP_OFF_POWER_CTRL, 0);
         chk_word(rdv, 32'(s) << 12);
         chk_word({30'h0, powerState}, 32'(s));
         cmd(1, `FLP_OFF_POWER_CTRL, 0);
         chk_bit(refd, 1'b1);
         cmd(1, `FLP_OFF_BYTE_TEST, 32'h0000_0000);
         chk_word({30'h0, powerState}, 32'h0);
         wait_ready(n);
         chk_bit(deviceReady, 1'b1);
      end
      cmd(1, `FLP_OFF_POWER_CTRL, 32'h0000_3000);
      chk_bit(refd, 1'b1);
      cmd(0, `FLP_OFF_POWER_CTRL, 0);
      chk_word(rdv, 32'h0000_0001);
      $display("power done");
   endtask

   task end_sim();
      $display("checks %0d miscompares %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // watchdog far beyond the test length
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("BAD %0t watchdog expired", $time);
      end_sim();
   end
   // main sequence
   initial begin
      reset_n = 1'b0;
      {cmdValid, cmdWrite, cmdAddr, cmdData, txDataReq, rxStatusPush, rxStatusPop} = '0;
      {rxFrameDone, rxFrameLen, rxDataPopDword, txStatusPush, txStatusPop} = '0;
      {txDataDrainDword, wakeFrameEvent, energyDetectEvent} = '0;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_levels();
      t_wake_pin();
      t_phy_reset();
      t_power_state();
      end_sim();
   end
endmodule
`default_nettype wire
